// ### rtl/clock_gen_map.svh
`ifndef CLOCK_GEN_MAP_SVH
`define CLOCK_GEN_MAP_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_PERIPH_ENABLE      8'h10
`define OFS_PERIPH_DISABLE     8'h14
`define OFS_PERIPH_STATUS      8'h18
`define OFS_MAIN_OSC_CONTROL   8'h20
`define OFS_MAIN_FREQ_MEASURE  8'h24
`define OFS_PLL_CONFIG         8'h2c
`define OFS_MASTER_CLOCK       8'h30
`define OFS_PROG_CLOCK0        8'h40
`define OFS_PROG_CLOCK1        8'h44
`define OFS_CLOCK_STATUS       8'h58
`define OFS_EVENT_STATUS       8'h68
`define OFS_EVENT_MASK         8'h6c

// ****************************************************************
// field positions and widths
// ****************************************************************
`define PERIPH_LOW_MASK        32'hffff_fffc
`define MOR_ENABLE_BIT         0
`define MOR_BYPASS_BIT         1
`define MOR_COUNT_LSB          8
`define MOR_COUNT_MSB          15
`define MOR_COUNT_SHIFT        3
`define MCFR_VALID_BIT         16
`define PLL_CFG_WIDTH          30
`define SEL_WIDTH              5
`define EVT_OSC_BIT            0
`define EVT_LOCK_BIT           2
`define EVT_MEAS_BIT           3
`define EVT_WIDTH              4

// ****************************************************************
// reset values and timing counts
// ****************************************************************
`define PLL_CONFIG_RESET       30'h0000_3f00
`define MEAS_WINDOW_LAST       4'hf
`define CLK_PERIOD_NS          10

`endif

// ### rtl/clock_gen_pkg.sv
`default_nettype none
package clock_gen_pkg;

  // pll register layout, bits 29:0
  typedef struct packed {
    logic [1:0]  usb_clock_ratio;
    logic        unused_bit;
    logic [10:0] pll_factor;
    logic [1:0]  out_range;
    logic [5:0]  pll_settle_count;
    logic [7:0]  in_div;
  } pll_cfg_t;

  // master and programmable clock layout, bits 4:0
  typedef struct packed {
    logic [2:0] clock_ratio_sel;
    logic [1:0] clock_source_sel;
  } clk_sel_t;

  typedef enum logic [1:0] {
    MEAS_IDLE,
    MEAS_ARM,
    MEAS_RUN,
    MEAS_DONE
  } meas_state_t;

endpackage
`default_nettype wire

// ### rtl/clock_gen_ctrl.sv
// Summary of operation
// - peripheral clock bits 31..2 read 1 while running; bits 1..0 unused
// - oscillator enable bit 0 starts/stops crystal; bypass must then be 0
// - without bypass, stable flag rises only after programmed start-up interval elapsed
// - start-up field bits 15..8 times 8 slow clock cycles
// - bypass bit 1 raises stable flag at once; enable kept 0
// - clearing enable and bypass clears the stable flag
// - count main clock over 16 slow periods into 16-bit field
// - measurement valid bit 16 set only with oscillator enabled and count ready
// - pll input divider: 0 no clock, 1 pass, 2..255 divide
// - after pll write count settle slow cycles, then raise lock
// - multiplier 0 turns pll off, else input times factor plus one
// - usb divider: 00 by 1, 01 by 2, 10 by 4, 11 reserved
// - source select 01 main, 11 pll, 10 reserved
// - prescaler codes 000..110 divide by 1..64, 111 reserved
// - source 00 selects slow clock for master and programmable clocks
// - stable flag reads 1 when oscillator stabilized, else 0
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_map.svh"

module clock_gen_ctrl (
  input  wire logic                     clk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic [7:0]               avs_address_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [31:0]              avs_writedata_i,
  input  wire logic [3:0]               avs_byteenable_i,
  output var  logic [31:0]              avs_readdata_o,
  output var  logic                     avs_waitrequest_o,
  input  wire logic                     slow_clk_i,
  input  wire logic                     main_clk_i,
  input  wire logic                     pll_clk_i,
  output var  logic [31:0]              periph_clock_bit_o,
  output var  logic                     main_osc_enable_o,
  output var  logic                     crystal_bypass_o,
  output var  logic                     main_osc_stable_flag_o,
  output var  logic                     pll_lock_o,
  output var  clock_gen_pkg::pll_cfg_t  pll_cfg_o,
  output var  logic [11:0]              pll_multiplier_o,
  output var  logic [2:0]               usb_divisor_o,
  output var  clock_gen_pkg::clk_sel_t  master_sel_o,
  output var  logic [3:0]               clk_tick_o,
  output var  logic                     irq_o
);

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // prescaler code to divisor, 0 means no output
  function automatic logic [7:0] ratio_div(input logic [2:0] code);
    logic [7:0] r;
    r = 8'h00;
    if (code != 3'h7) begin
      r = 8'h01 << code;
    end
    return r;
  endfunction

  function automatic logic src_tick(input logic [1:0] sel,
                                    input logic       slow_t,
                                    input logic       main_t,
                                    input logic       pll_t);
    logic r;
    r = 1'b0;
    case (sel)
      2'h0:    r = slow_t;
      2'h1:    r = main_t;
      2'h3:    r = pll_t;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [2:0] slow_sync;
  logic [2:0] main_sync;
  logic [2:0] pll_sync;
  logic       slow_tick;
  logic       main_tick;
  logic       pll_tick;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      slow_sync <= 3'h0;
      main_sync <= 3'h0;
      pll_sync  <= 3'h0;
    end else begin
      slow_sync <= {slow_sync[1:0], slow_clk_i};
      main_sync <= {main_sync[1:0], main_clk_i};
      pll_sync  <= {pll_sync[1:0], pll_clk_i};
    end
  end

  assign slow_tick = slow_sync[1] & ~slow_sync[2];
  assign main_tick = main_sync[1] & ~main_sync[2];
  assign pll_tick  = pll_sync[1] & ~pll_sync[2];

  // ****************************************************************
  // bus slave
  // ****************************************************************
  logic                     wr_go;
  logic [31:0]              wmerge;
  logic [7:0]               osc_count;
  logic [15:0]              main_freq_count;
  logic                     main_freq_valid;
  clock_gen_pkg::clk_sel_t  prog_sel [2];
  logic [`EVT_WIDTH-1:0]    evt_status;
  logic [`EVT_WIDTH-1:0]    evt_mask;
  logic [`EVT_WIDTH-1:0]    live_status;
  logic [31:0]              next_rdata;

  assign wr_go  = avs_write_i & ~avs_waitrequest_o;
  assign wmerge = be_merge(32'h0, avs_writedata_i, avs_byteenable_i);

  assign live_status = {1'b0, pll_lock_o, 1'b0, main_osc_stable_flag_o};

  always_comb begin
    next_rdata = 32'h0;
    case (avs_address_i)
      `OFS_PERIPH_STATUS:     next_rdata = periph_clock_bit_o;
      `OFS_MAIN_OSC_CONTROL:  next_rdata = {16'h0, osc_count, 6'h0,
                                            crystal_bypass_o, main_osc_enable_o};
      `OFS_MAIN_FREQ_MEASURE: next_rdata = {15'h0, main_freq_valid,
                                            main_freq_count};
      `OFS_PLL_CONFIG:        next_rdata = {2'h0, pll_cfg_o};
      `OFS_MASTER_CLOCK:      next_rdata = {27'h0, master_sel_o};
      `OFS_PROG_CLOCK0:       next_rdata = {27'h0, prog_sel[0]};
      `OFS_PROG_CLOCK1:       next_rdata = {27'h0, prog_sel[1]};
      `OFS_CLOCK_STATUS:      next_rdata = {28'h0, live_status};
      `OFS_EVENT_STATUS:      next_rdata = {28'h0, evt_status};
      `OFS_EVENT_MASK:        next_rdata = {28'h0, evt_mask};
      default:                next_rdata = 32'h0;
    endcase
  end

  // one wait cycle per access, answer in the second cycle
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
      if (avs_read_i & avs_waitrequest_o) begin
        avs_readdata_o <= next_rdata;
      end
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [31:0] pll_word;

  assign pll_word = be_merge({2'h0, pll_cfg_o}, avs_writedata_i, avs_byteenable_i);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      periph_clock_bit_o <= 32'h0;
    end else if (wr_go && avs_address_i == `OFS_PERIPH_ENABLE) begin
      periph_clock_bit_o <= (periph_clock_bit_o | wmerge) & `PERIPH_LOW_MASK;
    end else if (wr_go && avs_address_i == `OFS_PERIPH_DISABLE) begin
      periph_clock_bit_o <= periph_clock_bit_o & ~wmerge & `PERIPH_LOW_MASK;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pll_cfg_o    <= clock_gen_pkg::pll_cfg_t'(`PLL_CONFIG_RESET);
      master_sel_o <= '0;
      prog_sel[0]  <= '0;
      prog_sel[1]  <= '0;
      evt_mask     <= '0;
    end else if (wr_go) begin
      case (avs_address_i)
        `OFS_PLL_CONFIG:   pll_cfg_o <= clock_gen_pkg::pll_cfg_t'(pll_word[29:0]);
        `OFS_MASTER_CLOCK: begin
          if (avs_byteenable_i[0]) begin
            master_sel_o <= clock_gen_pkg::clk_sel_t'(avs_writedata_i[4:0]);
          end
        end
        `OFS_PROG_CLOCK0: begin
          if (avs_byteenable_i[0]) begin
            prog_sel[0] <= clock_gen_pkg::clk_sel_t'(avs_writedata_i[4:0]);
          end
        end
        `OFS_PROG_CLOCK1: begin
          if (avs_byteenable_i[0]) begin
            prog_sel[1] <= clock_gen_pkg::clk_sel_t'(avs_writedata_i[4:0]);
          end
        end
        `OFS_EVENT_MASK: begin
          if (avs_byteenable_i[0]) begin
            evt_mask <= avs_writedata_i[`EVT_WIDTH-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // main oscillator start-up
  // ****************************************************************
  logic        mor_wr;
  logic [31:0] mor_word;
  logic        new_en;
  logic        new_byp;
  logic [10:0] osc_cnt;
  logic        osc_counting;

  assign mor_wr   = wr_go && avs_address_i == `OFS_MAIN_OSC_CONTROL;
  assign mor_word = be_merge({16'h0, osc_count, 6'h0, crystal_bypass_o, main_osc_enable_o},
                             avs_writedata_i, avs_byteenable_i);
  assign new_en   = mor_word[`MOR_ENABLE_BIT];
  assign new_byp  = mor_word[`MOR_BYPASS_BIT];

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      main_osc_enable_o      <= 1'b0;
      crystal_bypass_o       <= 1'b0;
      osc_count              <= 8'h0;
      osc_cnt                <= 11'h0;
      osc_counting           <= 1'b0;
      main_osc_stable_flag_o <= 1'b0;
    end else if (mor_wr) begin
      main_osc_enable_o <= new_en;
      crystal_bypass_o  <= new_byp;
      osc_count         <= mor_word[`MOR_COUNT_MSB:`MOR_COUNT_LSB];
      if (new_byp) begin
        main_osc_stable_flag_o <= 1'b1;
        osc_counting           <= 1'b0;
      end else if (new_en && !main_osc_enable_o) begin
        osc_cnt <= {mor_word[`MOR_COUNT_MSB:`MOR_COUNT_LSB], 3'h0};
        osc_counting           <= 1'b1;
        main_osc_stable_flag_o <= 1'b0;
      end else if (!new_en) begin
        main_osc_stable_flag_o <= 1'b0;
        osc_counting           <= 1'b0;
      end
    end else if (osc_counting) begin
      if (osc_cnt == 11'h0) begin
        main_osc_stable_flag_o <= 1'b1;
        osc_counting           <= 1'b0;
      end else if (slow_tick) begin
        osc_cnt <= osc_cnt - 11'h1;
      end
    end
  end

  // ****************************************************************
  // main clock frequency measurement
  // ****************************************************************
  clock_gen_pkg::meas_state_t meas_state;
  logic [3:0]                 win_cnt;
  logic [15:0]                main_cnt;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meas_state      <= clock_gen_pkg::MEAS_IDLE;
      win_cnt         <= 4'h0;
      main_cnt        <= 16'h0;
      main_freq_count <= 16'h0;
      main_freq_valid <= 1'b0;
    end else if (!main_osc_enable_o || (mor_wr && !new_en)) begin
      meas_state      <= clock_gen_pkg::MEAS_IDLE;
      main_freq_valid <= 1'b0;
    end else begin
      case (meas_state)
        clock_gen_pkg::MEAS_IDLE: meas_state <= clock_gen_pkg::MEAS_ARM;
        clock_gen_pkg::MEAS_ARM: begin
          if (slow_tick) begin
            meas_state <= clock_gen_pkg::MEAS_RUN;
            win_cnt    <= 4'h0;
            main_cnt   <= 16'h0;
          end
        end
        clock_gen_pkg::MEAS_RUN: begin
          main_cnt <= main_cnt + {15'h0, main_tick};
          if (slow_tick) begin
            if (win_cnt == `MEAS_WINDOW_LAST) begin
              main_freq_count <= main_cnt + {15'h0, main_tick};
              main_freq_valid <= 1'b1;
              meas_state      <= clock_gen_pkg::MEAS_DONE;
            end else begin
              win_cnt <= win_cnt + 4'h1;
            end
          end
        end
        clock_gen_pkg::MEAS_DONE: meas_state <= clock_gen_pkg::MEAS_DONE;
        default: meas_state <= clock_gen_pkg::MEAS_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // pll lock counting and decode
  // ****************************************************************
  logic       pll_wr;
  logic [5:0] pll_cnt;
  logic       pll_counting;

  assign pll_wr = wr_go && avs_address_i == `OFS_PLL_CONFIG;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pll_lock_o   <= 1'b0;
      pll_cnt      <= 6'h0;
      pll_counting <= 1'b0;
    end else if (pll_wr) begin
      pll_lock_o   <= 1'b0;
      pll_cnt      <= pll_word[13:8];
      pll_counting <= pll_word[26:16] != 11'h0;
    end else if (pll_counting) begin
      if (pll_cnt == 6'h0) begin
        pll_lock_o   <= 1'b1;
        pll_counting <= 1'b0;
      end else if (slow_tick) begin
        pll_cnt <= pll_cnt - 6'h1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pll_multiplier_o <= 12'h0;
      usb_divisor_o    <= 3'h1;
    end else begin
      if (pll_cfg_o.pll_factor == 11'h0) begin
        pll_multiplier_o <= 12'h0;
      end else begin
        pll_multiplier_o <= {1'b0, pll_cfg_o.pll_factor} + 12'h1;
      end
      case (pll_cfg_o.usb_clock_ratio)
        2'h0:    usb_divisor_o <= 3'h1;
        2'h1:    usb_divisor_o <= 3'h2;
        2'h2:    usb_divisor_o <= 3'h4;
        default: usb_divisor_o <= 3'h0;
      endcase
    end
  end

  // ****************************************************************
  // clock tick dividers: master, prog0, prog1, pll reference
  // ****************************************************************
  logic [3:0] ch_src;
  logic [7:0] ch_div [4];
  logic [7:0] ch_cnt [4];

  always_comb begin
    ch_src[0] = src_tick(master_sel_o.clock_source_sel, slow_tick, main_tick, pll_tick);
    ch_src[1] = src_tick(prog_sel[0].clock_source_sel, slow_tick, main_tick, pll_tick);
    ch_src[2] = src_tick(prog_sel[1].clock_source_sel, slow_tick, main_tick, pll_tick);
    ch_src[3] = main_tick;
    ch_div[0] = ratio_div(master_sel_o.clock_ratio_sel);
    ch_div[1] = ratio_div(prog_sel[0].clock_ratio_sel);
    ch_div[2] = ratio_div(prog_sel[1].clock_ratio_sel);
    ch_div[3] = pll_cfg_o.in_div;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clk_tick_o <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        ch_cnt[c] <= 8'h0;
      end
    end else begin
      for (int c = 0; c < 4; c++) begin
        clk_tick_o[c] <= 1'b0;
        if (ch_src[c] && ch_div[c] != 8'h0) begin
          if (ch_cnt[c] >= ch_div[c] - 8'h1) begin
            clk_tick_o[c] <= 1'b1;
            ch_cnt[c]     <= 8'h0;
          end else begin
            ch_cnt[c] <= ch_cnt[c] + 8'h1;
          end
        end
      end
    end
  end

  // ****************************************************************
  // events and interrupt
  // ****************************************************************
  logic [`EVT_WIDTH-1:0] evt_set;
  logic [`EVT_WIDTH-1:0] evt_clr;
  logic                  stable_q;
  logic                  lock_q;
  logic                  valid_q;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stable_q <= 1'b0;
      lock_q   <= 1'b0;
      valid_q  <= 1'b0;
    end else begin
      stable_q <= main_osc_stable_flag_o;
      lock_q   <= pll_lock_o;
      valid_q  <= main_freq_valid;
    end
  end

  assign evt_set = {main_freq_valid & ~valid_q, pll_lock_o & ~lock_q, 1'b0,
                    main_osc_stable_flag_o & ~stable_q};
  assign evt_clr = (wr_go && avs_address_i == `OFS_EVENT_STATUS && avs_byteenable_i[0])
                   ? avs_writedata_i[`EVT_WIDTH-1:0] : '0;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      evt_status <= '0;
      irq_o      <= 1'b0;
    end else begin
      evt_status <= (evt_status & ~evt_clr) | evt_set;
      irq_o      <= |(evt_status & evt_mask);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_pll_write;
    pll_wr;
  endsequence

  sequence s_pll_cleared;
    !pll_lock_o && pll_cnt == $past(pll_word[13:8]);
  endsequence

  sequence s_meas_end;
    meas_state == clock_gen_pkg::MEAS_RUN && slow_tick && win_cnt == 4'hf && !(mor_wr && !new_en);
  endsequence

  a_osc_stable_wait: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(main_osc_stable_flag_o) |-> crystal_bypass_o || $past(osc_counting && osc_cnt == 11'h0))
    else $error("stable flag rose before start-up interval");
  a_osc_load_count: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mor_wr && new_en && !new_byp && !main_osc_enable_o
    |=> osc_cnt == {$past(mor_word[15:8]), 3'h0} && !main_osc_stable_flag_o)
    else $error("start-up count not loaded as field times 8");
  a_bypass_stable: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mor_wr && new_byp |=> main_osc_stable_flag_o)
    else $error("bypass did not raise stable flag");
  a_osc_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mor_wr && !new_en && !new_byp |=> !main_osc_stable_flag_o)
    else $error("stable flag not cleared");
  a_meas_store: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_meas_end |=> main_freq_valid && main_freq_count == $past(main_cnt + {15'h0, main_tick}))
    else $error("measurement not stored at window end");
  a_meas_invalid: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !main_osc_enable_o |=> !main_freq_valid)
    else $error("valid set while oscillator disabled");
  a_pll_unlock: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_pll_write |=> s_pll_cleared)
    else $error("pll write did not restart lock count");
  a_periph_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    periph_clock_bit_o[1:0] == 2'h0)
    else $error("unused peripheral bits set");
  a_usb_code: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    pll_cfg_o.usb_clock_ratio == 2'h2 && $stable(pll_cfg_o) |=> usb_divisor_o == 3'h4)
    else $error("usb divider code 10 not divide by 4");

endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_map.svh"
module tb_top;
  logic clk_i = 0, sys_rst_i = 1, avs_read_i = 0, avs_write_i = 0;
  logic [7:0] avs_address_i = 0;
  logic [31:0] avs_writedata_i = 0, avs_readdata_o, periph_clock_bit_o, q;
  logic [3:0] avs_byteenable_i = 4'hf, clk_tick_o;
  logic avs_waitrequest_o, main_osc_enable_o, crystal_bypass_o, main_osc_stable_flag_o;
  logic pll_lock_o, irq_o, slow_clk_i = 0, main_clk_i = 0, pll_clk_i = 0;
  logic [11:0] pll_multiplier_o;
  logic [2:0] usb_divisor_o;
  clock_gen_pkg::pll_cfg_t pll_cfg_o;
  clock_gen_pkg::clk_sel_t master_sel_o;
  int err_total = 0, samples_checked = 0, i, n, m, z, cnt = 0;
  clock_gen_ctrl dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .slow_clk_i(slow_clk_i), .main_clk_i(main_clk_i),
    .pll_clk_i(pll_clk_i), .periph_clock_bit_o(periph_clock_bit_o),
    .main_osc_enable_o(main_osc_enable_o), .crystal_bypass_o(crystal_bypass_o),
    .main_osc_stable_flag_o(main_osc_stable_flag_o), .pll_lock_o(pll_lock_o),
    .pll_cfg_o(pll_cfg_o), .pll_multiplier_o(pll_multiplier_o), .usb_divisor_o(usb_divisor_o),
    .master_sel_o(master_sel_o), .clk_tick_o(clk_tick_o), .irq_o(irq_o));
  // ****************************************************************
  // clocks: slow period 16 cycles, main 4, pll 6
  // ****************************************************************
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cnt <= cnt + 1;
    if (cnt % 8 == 7) slow_clk_i <= ~slow_clk_i;
    if (cnt % 2 == 1) main_clk_i <= ~main_clk_i;
    if (cnt % 3 == 2) pll_clk_i <= ~pll_clk_i;
  end
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !w;
    avs_write_i <= w;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 50);
    q = avs_readdata_o;
    avs_read_i <= 0;
    avs_write_i <= 0;
    @(posedge clk_i);
    if (k >= 50) begin
      err_total++;
      complete_run();
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs();
    bus(0, `OFS_PLL_CONFIG, 0); check("pll_reset", 32'h0000_3f00, q);
    bus(1, `OFS_PERIPH_ENABLE, 32'hffff_ffff); bus(0, `OFS_PERIPH_STATUS, 0);
    check("periph_status", 32'hffff_fffc, q);
    bus(1, `OFS_PERIPH_DISABLE, 32'h0000_00f0); bus(0, `OFS_PERIPH_STATUS, 0);
    check("periph_status", 32'hffff_ff0c, q);
    check("periph_pins", 32'hffff_ff0c, periph_clock_bit_o);
    bus(0, 8'h7c, 0); check("unmapped", 32'h0, q);
    $display("test regs done");
  endtask
  task automatic t_osc();
    bus(1, `OFS_EVENT_MASK, 32'h1); bus(1, `OFS_EVENT_STATUS, 32'hf); idle(2);
    check("irq_clear", 0, irq_o);
    bus(1, `OFS_MAIN_OSC_CONTROL, 32'h0000_0201); check("osc_en", 1, main_osc_enable_o);
    idle(200); check("early_stable", 0, main_osc_stable_flag_o);
    for (i = 0; i < 150 && main_osc_stable_flag_o !== 1'b1; i++) idle(1);
    check("stable", 1, main_osc_stable_flag_o);
    idle(3); check("irq_set", 1, irq_o);
    bus(0, `OFS_EVENT_STATUS, 0); check("evt_stable", 1, q[0]);
    bus(0, `OFS_CLOCK_STATUS, 0); check("status_bit0", 1, q[0]);
    for (n = 0; n < 200 && q[16] !== 1'b1; n++) bus(0, `OFS_MAIN_FREQ_MEASURE, 0);
    check("freq_valid", 1, q[16]);
    check("freq_in_range", 1, q[15:0] >= 63 && q[15:0] <= 65);
    bus(1, `OFS_EVENT_STATUS, 32'h1); idle(2); check("irq_clear", 0, irq_o);
    bus(1, `OFS_MAIN_OSC_CONTROL, 0); idle(2);
    check("stable_off", 0, main_osc_stable_flag_o);
    bus(0, `OFS_MAIN_FREQ_MEASURE, 0); check("valid_off", 0, q[16]);
    bus(1, `OFS_MAIN_OSC_CONTROL, 32'h0000_0002); idle(1);
    check("bypass_stable", 1, main_osc_stable_flag_o);
    check("bypass_bit", 1, crystal_bypass_o);
    bus(1, `OFS_MAIN_OSC_CONTROL, 0);
    $display("test osc done");
  endtask
  task automatic t_pll();
    bus(1, `OFS_PLL_CONFIG, 32'h0005_0401); check("lock_clr", 0, pll_lock_o);
    idle(1); check("mult", 12'd6, pll_multiplier_o);
    check("in_div", 8'd1, pll_cfg_o.in_div);
    idle(30); check("early_lock", 0, pll_lock_o);
    for (i = 0; i < 120 && pll_lock_o !== 1'b1; i++) idle(1);
    check("lock", 1, pll_lock_o);
    bus(1, `OFS_PLL_CONFIG, 32'h0005_0402); check("relock_clr", 0, pll_lock_o);
    bus(1, `OFS_PLL_CONFIG, 32'h0000_0401); idle(1);
    check("mult_off", 0, pll_multiplier_o);
    for (n = 0; n < 4; n++) begin
      bus(1, `OFS_PLL_CONFIG, (n << 28) | 32'h0001_0400);
      idle(1);
      check("usb_div", n == 3 ? 0 : 1 << n, usb_divisor_o);
    end
    $display("test pll done");
  endtask
  task automatic t_master();
    bus(1, `OFS_MASTER_CLOCK, 32'h0000_0004);
    check("master_sel", 5'h04, master_sel_o);
    bus(1, `OFS_PROG_CLOCK0, 32'h0000_0009); bus(1, `OFS_PROG_CLOCK1, 32'h0000_0002);
    bus(0, `OFS_PROG_CLOCK0, 0); check("prog0_sel", 32'h0000_0009, q);
    n = 0;
    m = 0;
    z = 0;
    for (i = 0; i < 640; i++) begin
      idle(1);
      if (clk_tick_o[0] === 1'b1) n++;
      if (clk_tick_o[1] === 1'b1) m++;
      if (clk_tick_o[2] !== 1'b0 || clk_tick_o[3] !== 1'b0) z++;
    end
    check("master_ticks_ok", 1, n >= 19 && n <= 21);
    check("prog0_ticks_ok", 1, m >= 39 && m <= 41);
    check("reserved_ticks", 0, z);
    bus(1, `OFS_MASTER_CLOCK, 32'h0000_0003); check("pll_sel", 5'h03, master_sel_o);
    n = 0;
    for (i = 0; i < 600; i++) begin
      idle(1);
      if (clk_tick_o[0] === 1'b1) n++;
    end
    check("pll_ticks_ok", 1, n >= 99 && n <= 101);
    $display("test master done");
  endtask
  initial begin
    idle(5);
    sys_rst_i <= 0;
    idle(1);
    t_regs();
    t_osc();
    t_pll();
    t_master();
    complete_run();
  end
endmodule
`default_nettype wire
